/* File: pkg/dcs_pkg.sv */
// package for the drive command source select block
// Notes on behaviour
// R1: station address range depends on protocol; default address is 1.
// R2: serial-link writes of the station address are refused; panel only.
// R3: rate code 0..5 means 300..9600 bit/s; default code 5.
// R4: serial-link writes of the rate code are ignored; panel only.
// R5: the serial master runs at the configured rate; no rate detection.
// R6: selector code 0 input, 1 serial, 2 and-merge, 3 or-merge; default 3.
// R7: serial-only mode follows the serial bit and ignores the input.
// R8: and-merge activates the command only if the input requests it too.
// R9: coast input and control bit 03 are active low.
// R10: coast merge: 2 coasts when both low, 3 runs when both high.
// R11: quick-stop input and control bit 04 are active low.
// R12: quick-stop uses the same four-mode merge as coasting.
// R13: brake has its own four-mode selector, same codes, default or-merge.
// R14: brake input and control bit 02 are active low.
// R15: merged outputs are registered so selector changes act glitch free.
package dcs_pkg;

  typedef enum logic [1:0] {
    DCS_SRC_INPUT  = 2'b00,
    DCS_SRC_SERIAL = 2'b01,
    DCS_SRC_AND    = 2'b10,
    DCS_SRC_OR     = 2'b11
  } dcs_src_t;

  typedef enum logic [1:0] {
    DCS_PROTO_NATIVE = 2'b00,
    DCS_PROTO_BAS    = 2'b01,
    DCS_PROTO_RSVD   = 2'b10,
    DCS_PROTO_MODBUS = 2'b11
  } dcs_proto_t;

  // wishbone register offsets (byte addresses)
  localparam logic [3:0] DCS_ADR_CFG    = 4'h0;
  localparam logic [3:0] DCS_ADR_SEL    = 4'h4;
  localparam logic [3:0] DCS_ADR_CTRL   = 4'h8;
  localparam logic [3:0] DCS_ADR_STATUS = 4'hc;

  // field positions
  localparam int DCS_CFG_ADDR_LSB  = 0;
  localparam int DCS_CFG_RATE_LSB  = 8;
  localparam int DCS_CFG_PROTO_LSB = 12;
  localparam int DCS_CFG_REJ_BIT   = 16;
  localparam int DCS_SEL_COAST_LSB = 0;
  localparam int DCS_SEL_QSTOP_LSB = 2;
  localparam int DCS_SEL_BRAKE_LSB = 4;
  localparam int DCS_CW_BRAKE_BIT  = 2;
  localparam int DCS_CW_COAST_BIT  = 3;
  localparam int DCS_CW_QSTOP_BIT  = 4;

  // reset values
  localparam logic [7:0]  DCS_ADDR_RST  = 8'h01;
  localparam logic [2:0]  DCS_RATE_RST  = 3'h5;
  localparam dcs_src_t    DCS_SRC_RST   = DCS_SRC_OR;
  localparam dcs_proto_t  DCS_PROTO_RST = DCS_PROTO_NATIVE;
  localparam logic [15:0] DCS_CW_RST    = 16'hffff;

  // address limits per protocol
  localparam logic [7:0] DCS_NATIVE_MIN = 8'h00;
  localparam logic [7:0] DCS_NATIVE_MAX = 8'hf7;
  localparam logic [7:0] DCS_BAS_MIN    = 8'h01;
  localparam logic [7:0] DCS_BAS_MAX    = 8'hff;
  localparam logic [7:0] DCS_MODBUS_MIN = 8'h01;
  localparam logic [7:0] DCS_MODBUS_MAX = 8'hf7;
  localparam logic [2:0] DCS_RATE_MAX   = 3'h5;

  // bit rates per code
  localparam logic [13:0] DCS_BAUD_300  = 14'd300;
  localparam logic [13:0] DCS_BAUD_600  = 14'd600;
  localparam logic [13:0] DCS_BAUD_1200 = 14'd1200;
  localparam logic [13:0] DCS_BAUD_2400 = 14'd2400;
  localparam logic [13:0] DCS_BAUD_4800 = 14'd4800;
  localparam logic [13:0] DCS_BAUD_9600 = 14'd9600;

  typedef struct packed {
    logic coast_n;
    logic qstop_n;
    logic brake_n;
  } dcs_cmd_t;

endpackage

/* File: hdl/dcs_top.sv */
// drive command source select: configuration registers and command merge
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module dcs_top
  import dcs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        panel_we_i,
  input  wire logic [7:0]  panel_addr_i,
  input  wire logic [2:0]  panel_rate_i,
  input  wire logic [1:0]  panel_proto_i,
  input  wire dcs_cmd_t    din_n_i,
  output logic      [7:0]  station_addr_o,
  output logic      [2:0]  rate_code_o,
  output logic      [13:0] baud_o,
  output dcs_cmd_t         cmd_n_o
);

  logic [7:0]  station_addr;
  logic [2:0]  rate_code;
  dcs_proto_t  proto;
  dcs_src_t    sel_coast;
  dcs_src_t    sel_qstop;
  dcs_src_t    sel_brake;
  logic [15:0] ctrl_word;
  logic        cfg_rejected;
  dcs_cmd_t    cmd_n;
  logic        bus_req;
  logic        bus_wr;
  logic        addr_ok;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic [31:0] next_rdata;
  dcs_cmd_t    next_cmd_n;
  dcs_proto_t  panel_proto;

  assign panel_proto = dcs_proto_t'(panel_proto_i);
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i;

  // address limits follow the protocol being configured alongside it
  always_comb begin
    case (panel_proto)
      DCS_PROTO_NATIVE: begin
        lo = DCS_NATIVE_MIN;
        hi = DCS_NATIVE_MAX;
      end
      DCS_PROTO_BAS: begin
        lo = DCS_BAS_MIN;
        hi = DCS_BAS_MAX;
      end
      DCS_PROTO_MODBUS: begin
        lo = DCS_MODBUS_MIN;
        hi = DCS_MODBUS_MAX;
      end
      default: begin
        lo = DCS_NATIVE_MIN;
        hi = DCS_NATIVE_MAX;
      end
    endcase
    addr_ok = (panel_addr_i >= lo) && (panel_addr_i <= hi); // [R1]
  end

  // panel writes a whole set; out-of-range address or rate leaves all unchanged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      station_addr <= DCS_ADDR_RST; // [R1]
      rate_code    <= DCS_RATE_RST; // [R3]
      proto        <= DCS_PROTO_RST;
    end else if (panel_we_i && addr_ok && panel_rate_i <= DCS_RATE_MAX
                 && panel_proto != DCS_PROTO_RSVD) begin
      station_addr <= panel_addr_i; // [R1]
      rate_code    <= panel_rate_i; // [R3]
      proto        <= panel_proto;
    end
  end

  // bus writes to the config word never touch address or rate; they only flag it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_rejected <= 1'b0;
    end else if (bus_wr && wb_adr_i == DCS_ADR_CFG && wb_sel_i != 4'h0) begin
      cfg_rejected <= 1'b1; // [R2] [R4]
    end else if (bus_wr && wb_adr_i == DCS_ADR_STATUS && wb_sel_i[0] && wb_dat_i[0]) begin
      cfg_rejected <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_coast <= DCS_SRC_RST; // [R6] [R13]
      sel_qstop <= DCS_SRC_RST;
      sel_brake <= DCS_SRC_RST;
    end else if (bus_wr && wb_adr_i == DCS_ADR_SEL && wb_sel_i[0]) begin
      sel_coast <= dcs_src_t'(wb_dat_i[DCS_SEL_COAST_LSB +: 2]);
      sel_qstop <= dcs_src_t'(wb_dat_i[DCS_SEL_QSTOP_LSB +: 2]);
      sel_brake <= dcs_src_t'(wb_dat_i[DCS_SEL_BRAKE_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_word <= DCS_CW_RST;
    end else if (bus_wr && wb_adr_i == DCS_ADR_CTRL) begin
      if (wb_sel_i[0]) ctrl_word[7:0]  <= wb_dat_i[7:0];
      if (wb_sel_i[1]) ctrl_word[15:8] <= wb_dat_i[15:8];
    end
  end

  // all levels are active low: 0 asks for the stop action
  function automatic logic merge_n(input dcs_src_t mode, input logic din_n, input logic ser_n);
    case (mode)
      DCS_SRC_INPUT:  merge_n = din_n;
      DCS_SRC_SERIAL: merge_n = ser_n;           // [R7]
      DCS_SRC_AND:    merge_n = din_n | ser_n;   // [R8]
      DCS_SRC_OR:     merge_n = din_n & ser_n;
      default:        merge_n = din_n & ser_n;
    endcase
  endfunction

  always_comb begin
    next_cmd_n.coast_n = merge_n(sel_coast, din_n_i.coast_n, ctrl_word[DCS_CW_COAST_BIT]); // [R9] [R10]
    next_cmd_n.qstop_n = merge_n(sel_qstop, din_n_i.qstop_n, ctrl_word[DCS_CW_QSTOP_BIT]); // [R11] [R12]
    next_cmd_n.brake_n = merge_n(sel_brake, din_n_i.brake_n, ctrl_word[DCS_CW_BRAKE_BIT]); // [R13] [R14]
  end

  // registered so a selector change cannot glitch the drive commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_n <= '{coast_n: 1'b0, qstop_n: 1'b0, brake_n: 1'b0};
    end else begin
      cmd_n <= next_cmd_n; // [R15]
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      DCS_ADR_CFG: begin
        next_rdata[DCS_CFG_ADDR_LSB +: 8]  = station_addr;
        next_rdata[DCS_CFG_RATE_LSB +: 3]  = rate_code;
        next_rdata[DCS_CFG_PROTO_LSB +: 2] = proto;
      end
      DCS_ADR_SEL: begin
        next_rdata[DCS_SEL_COAST_LSB +: 2] = sel_coast;
        next_rdata[DCS_SEL_QSTOP_LSB +: 2] = sel_qstop;
        next_rdata[DCS_SEL_BRAKE_LSB +: 2] = sel_brake;
      end
      DCS_ADR_CTRL:   next_rdata[15:0] = ctrl_word;
      DCS_ADR_STATUS: begin
        next_rdata[0] = cfg_rejected;
        next_rdata[3:1] = {cmd_n.brake_n, cmd_n.qstop_n, cmd_n.coast_n};
      end
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // one wait-free ack per request; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? next_rdata : 32'h0000_0000;
    end
  end

  always_comb begin
    case (rate_code)
      3'h0:    baud_o = DCS_BAUD_300; // [R3]
      3'h1:    baud_o = DCS_BAUD_600;
      3'h2:    baud_o = DCS_BAUD_1200;
      3'h3:    baud_o = DCS_BAUD_2400;
      3'h4:    baud_o = DCS_BAUD_4800;
      default: baud_o = DCS_BAUD_9600;
    endcase
  end

  assign station_addr_o = station_addr;
  assign rate_code_o    = rate_code;
  assign cmd_n_o        = cmd_n;

endmodule

/* File: tb/dcs_top_properties.sv */
// port-level checks for the command source select block
`timescale 1ns/1ps
module dcs_top_properties
  import dcs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic        panel_we_i,
  input wire logic [7:0]  panel_addr_i,
  input wire logic [2:0]  panel_rate_i,
  input wire logic [1:0]  panel_proto_i,
  input wire dcs_cmd_t    din_n_i,
  input wire logic [7:0]  station_addr_o,
  input wire logic [2:0]  rate_code_o,
  input wire logic [13:0] baud_o,
  input wire dcs_cmd_t    cmd_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  sequence cfg_wr_s;
    wr && wb_adr_i == DCS_ADR_CFG && !panel_we_i;
  endsequence
  // a selector or control-word write may move a command, so only spans with no bus write at all are held
  sequence quiet_s;
    !wr ##1 (!wr && $stable(din_n_i));
  endsequence
  a_range_native: assert property (panel_we_i && panel_proto_i == 2'h0 && panel_addr_i > 8'hf7 |=> $stable(station_addr_o))
    else $error("native address above range taken");
  a_range_bas: assert property (panel_we_i && panel_proto_i == 2'h1 && panel_addr_i == 8'h00 |=> $stable(station_addr_o))
    else $error("zero address taken for building protocol");
  a_addr_accept: assert property (panel_we_i && panel_proto_i == 2'h3 && panel_addr_i inside {[8'h01:8'hf7]}
    && panel_rate_i <= 3'h5 |=> station_addr_o == $past(panel_addr_i)) else $error("legal address not taken");
  a_serial_refused: assert property (cfg_wr_s |=> $stable(station_addr_o))
    else $error("station address changed by bus write");
  a_rate_refused: assert property (cfg_wr_s |=> $stable(rate_code_o))
    else $error("rate changed by bus write");
  a_baud_decode: assert property (rate_code_o <= 3'h5 && baud_o == 14'd300 << rate_code_o)
    else $error("bit rate decode wrong");
  a_stop_reset: assert property ($past(rst_i) |-> cmd_n_o == 3'b000)
    else $error("stop actions not asserted by reset");
  a_cmd_hold: assert property (quiet_s |=> $stable(cmd_n_o))
    else $error("command moved without a cause");
endmodule
bind dcs_top dcs_top_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
  .panel_we_i, .panel_addr_i, .panel_rate_i, .panel_proto_i, .din_n_i, .station_addr_o, .rate_code_o, .baud_o,
  .cmd_n_o);

/* File: tb/dcs_master.sv */
// serial master model: one classic bus cycle per request, held until ack
`timescale 1ns/1ps
module dcs_master
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [36:0] req_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic      [36:0] req_o,
  output logic      [31:0] rd_o,
  output logic             done_o
);
  // link rate is whatever the drive holds; the model never probes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_o  <= 1'b0;
      done_o <= 1'b0;
      req_o  <= '0;
    end else if (cyc_o && ack_i) begin
      cyc_o  <= 1'b0;
      rd_o   <= rdat_i;
      done_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      if (go_i && !cyc_o && !done_o) begin
        cyc_o <= 1'b1;
        req_o <= req_i;
      end else if (!cyc_o) begin
        // released lines must not look like a held request
        req_o <= ~req_o;
      end
    end
  end
endmodule

/* File: tb/drive_command_source_select_bench.sv */
// self-checking bench for the command source select block
`timescale 1ns/1ps
module drive_command_source_select_bench
  import dcs_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        go = 1'b0;
  logic        pwe = 1'b0;
  logic [36:0] req = '0;
  logic [12:0] pv = '0;
  logic [31:0] seed = 32'ha9ae;
  dcs_cmd_t    din = 3'b111;
  logic [36:0] mreq;
  logic [31:0] rd, dato;
  logic        cyc, ack, done;
  logic [7:0]  sa, ea;
  logic [2:0]  rc;
  logic [13:0] bd;
  dcs_cmd_t    cmd;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [13:0] tbl [10] = '{14'h27bd, 14'h07c5, 14'h2ffd, 14'h0805, 14'h1805, 14'h1fc5, 14'h380d, 14'h1085,
                            14'h2005, 14'h004e};
  dcs_master u_mst (.clk_i, .rst_i, .go_i(go), .req_i(req), .ack_i(ack), .rdat_i(dato), .cyc_o(cyc),
    .req_o(mreq), .rd_o(rd), .done_o(done));
  dcs_top dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc === 1'b1), .wb_stb_i(cyc === 1'b1), .wb_we_i(mreq[36]),
    .wb_adr_i(mreq[35:32]), .wb_sel_i(4'hf), .wb_dat_i(mreq[31:0]), .wb_dat_o(dato), .wb_ack_o(ack),
    .panel_we_i(pwe), .panel_addr_i(pv[10:3]), .panel_rate_i(pv[2:0]), .panel_proto_i(pv[12:11]),
    .din_n_i(din), .station_addr_o(sa), .rate_code_o(rc), .baud_o(bd), .cmd_n_o(cmd));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic mrg(input logic [1:0] m, input logic d, input logic s);
    return m == 2'h0 ? d : m == 2'h1 ? s : m == 2'h2 ? (d | s) : (d & s);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    go  <= 1'b1;
    req <= {w, a, d};
    do @(negedge clk_i); while (done !== 1'b1);
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register read", e, rd);
  endtask
  task automatic panel(input logic [12:0] v);
    @(posedge clk_i);
    pwe <= 1'b1;
    pv  <= v;
    @(posedge clk_i);
    pwe <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("cmd in reset", 32'h0, cmd);
    @(negedge clk_i);
    chk("cmd default", 32'h7, cmd);
    chk("baud default", 32'd9600, bd);
    chk("address default", 32'h1, sa);
    rdchk(DCS_ADR_SEL, 32'h3f);
    rdchk(DCS_ADR_CTRL, 32'hffff);
    bus(1'b1, DCS_ADR_CFG, 32'h0000_3312);
    rdchk(DCS_ADR_CFG, 32'h0501);
    rdchk(DCS_ADR_STATUS, 32'hf);
    bus(1'b1, DCS_ADR_STATUS, 32'h1);
    rdchk(DCS_ADR_STATUS, 32'he);
    rdchk(4'h1, 32'h0);
    ea = 8'h01;
    for (int i = 0; i < 10; i++) begin
      panel(tbl[i][12:0]);
      if (tbl[i][13])
        ea = tbl[i][10:3];
      chk("station address", ea, sa);
    end
    for (int r = 0; r < 6; r++) begin
      panel({2'h0, 8'h05, r[2:0]});
      chk("rate code", r, rc);
      chk("baud", 14'd300 << r, bd);
    end
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      bus(1'b1, DCS_ADR_SEL, {26'h0, seed[5:0]});
      bus(1'b1, DCS_ADR_CTRL, {16'h0, seed[21:6]});
      din <= seed[24:22];
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("cmd", {mrg(seed[1:0], seed[24], seed[9]), mrg(seed[3:2], seed[23], seed[10]), mrg(seed[5:4], seed[22],
        seed[8])}, cmd);
    end
    report_and_stop();
  end
endmodule
